// >>> logic/lmsc_consts.vh
/*
  Constants of the modem command interpreter: opcodes, lengths, status
  field positions, error codes and frequency defaults.
  Assumes inclusion by bare name from the design file.
*/
// Notes on behaviour
// R1: Status bit6 ready, bit5 sent, bit0 amplifier
// R2: Status bits 4..1 hold device error code
// R3: Library status byte holds code 0x00..0x10
// R4: Status read: two dummies then three bytes
// R5: Send-bit command transmits 0/1, then event
// R6: Send-frame command starts transmission, event at end
// R7: Host fills transmit buffer before sending
// R8: Send-receive runs, event, result via readout
// R9: Registration code: 16 bytes, upper eight zero
// R10: Receive readout returns eight bytes, byte0 first
// R11: Config write: four bytes, stored, then event
// R12: Direction 1 means output; level sets drive/pull-up
// R13: Identifier: four bytes, most significant first
// R14: Supply/temperature: three words, high byte first
// R15: Host converts temperature: subtract 500, divide 10
// R16: Measure command raises event; supply read clears
// R17: Transmit test takes frames and channel words
// R18: Receive test takes sequence and channel words
// R19: Carrier on with 0x11, off with 0x00
// R20: Transmit frequency word, default, lost at reset
// R21: Receive frequency word, default, lost at reset
// R22: Status read clears event and status bytes
// R23: Event low on ready and completions
// R24: Host uses mode 0, MSB first, slow clock
// R25: Front-end pins follow uplink/downlink/disabled
// R26: One command per chip-select frame
`ifndef LMSC_CONSTS_VH
`define LMSC_CONSTS_VH

`define LMSC_OP_STATUS    8'h0a
`define LMSC_OP_SEND_BIT  8'h0b
`define LMSC_OP_SEND_FRM  8'h0d
`define LMSC_OP_SEND_RCV  8'h0e
`define LMSC_OP_REG_CODE  8'h0f
`define LMSC_OP_RX_READ   8'h10
`define LMSC_OP_SYS_CONF  8'h11
`define LMSC_OP_GET_ID    8'h12
`define LMSC_OP_SUPPLY    8'h13
`define LMSC_OP_MEASURE   8'h14
`define LMSC_OP_TX_TEST   8'h15
`define LMSC_OP_RX_TEST   8'h16
`define LMSC_OP_CARRIER   8'h17
`define LMSC_OP_TX_FREQ   8'h1b
`define LMSC_OP_RX_FREQ   8'h1c

`define LMSC_CARRIER_ON   8'h11
`define LMSC_CARRIER_OFF  8'h00
`define LMSC_CONF_MARK    8'h02

`define LMSC_FIRST_DATA   5'h02
`define LMSC_REG_CODE_USED 5'h08
`define LMSC_IDX_MAX      5'h1f

`define LMSC_ST_READY     6
`define LMSC_ST_SENT      5
`define LMSC_ST_ERR_HI    4
`define LMSC_ST_ERR_LO    1
`define LMSC_ST_AMP       0

`define LMSC_ERR_NONE     4'h0
`define LMSC_ERR_CMD      4'h1
`define LMSC_ERR_USAGE    4'h4
`define LMSC_LIB_NONE     8'h00

`define LMSC_TX_FREQ_DEF  32'h33be9cd0
`define LMSC_RX_FREQ_DEF  32'h33d3e608

`endif

// >>> logic/lmsc_cmd.v
/*
  Command interpreter of the radio modem, seen from inside the device:
  an SPI slave (mode 0, MSB first) sampled by ref_clk, opcode decode,
  parameter capture, result byte streaming, status and event handling.
  Assumes a radio/measurement engine on ref_clk that takes the start
  pulses and reports completion with one-cycle done pulses, and an SPI
  clock far slower than ref_clk.
*/
`include "lmsc_consts.vh"

module lmsc_cmd (
  // Clock and reset
  input  wire        ref_clk,
  input  wire        rst_b,
  // SPI pins from the host
  input  wire        sclk,
  input  wire        cs_b,
  input  wire        mosi,
  output reg         miso,
  output reg         miso_oe,
  // Event and front-end pins
  output reg         completion_event_pin_b,
  output reg         front_end_enable_pin,
  output reg         front_end_direction_pin,
  // Engine state and results
  input  wire [7:0]  hardware_state_status,
  input  wire        amp_on,
  input  wire        uplink_active,
  input  wire        downlink_active,
  input  wire        radio_done,
  input  wire        radio_frame_sent,
  input  wire [3:0]  radio_error_code,
  input  wire [7:0]  radio_lib_status,
  input  wire        meas_done,
  input  wire        nv_done,
  input  wire [63:0] rx_packet,
  input  wire [63:0] registration_code,
  input  wire [31:0] device_identifier,
  input  wire [15:0] idle_supply_mv,
  input  wire [15:0] active_supply_mv,
  input  wire [15:0] raw_temperature_word,
  // Commands to the engine
  output reg         send_bit_start,
  output reg         send_bit_value,
  output reg         send_frame_start,
  output reg         send_recv_start,
  output reg         meas_start,
  output reg         nv_write_start,
  output reg  [7:0]  port_direction_byte,
  output reg  [7:0]  port_level_byte,
  output reg  [7:0]  system_config_byte,
  output reg         tx_test_start,
  output reg  [15:0] frame_count,
  output reg         rx_test_start,
  output reg  [15:0] sequence_word,
  output reg  [15:0] channel_word,
  output reg         continuous_carrier,
  output reg  [31:0] tx_freq_hz,
  output reg  [31:0] rx_freq_hz
);

  reg  [2:0]  sclk_sy;
  reg  [2:0]  cs_sy;
  reg  [1:0]  mosi_sy;
  reg  [2:0]  bit_cnt;
  reg  [7:0]  rx_sh;
  reg  [7:0]  tx_sh;
  reg  [4:0]  byte_idx;
  reg  [7:0]  opcode;
  reg  [31:0] param;
  reg         done_cmd;
  reg  [23:0] status_snap;
  reg         sys_ready;
  reg         frame_sent;
  reg  [3:0]  err_code;
  reg  [7:0]  lib_status;
  reg         ev_ready;
  reg         ev_radio;
  reg         ev_meas;
  reg         ev_nv;
  reg  [2:0]  param_len;
  reg  [7:0]  next_tx_byte;
  reg  [4:0]  data_idx;

  wire        sclk_rise = sclk_sy[1] & ~sclk_sy[2];
  wire        sclk_fall = ~sclk_sy[1] & sclk_sy[2];
  wire        cs_act    = ~cs_sy[1];
  wire        byte_done = cs_act & sclk_rise & (bit_cnt == 3'h7);
  wire [7:0]  rx_byte   = {rx_sh[6:0], mosi_sy[1]};
  wire [7:0]  cur_op    = (byte_idx == 5'h00) ? rx_byte : opcode;
  wire [4:0]  next_idx  = (byte_idx == `LMSC_IDX_MAX) ? byte_idx : byte_idx + 5'h01;
  wire        is_last_param = byte_done & ~done_cmd & (byte_idx != 5'h00) & (byte_idx[2:0] == param_len);
  wire        op_taken  = byte_done & (byte_idx == 5'h00);
  wire        status_rd = op_taken & (rx_byte == `LMSC_OP_STATUS);
  wire        supply_rd = op_taken & (rx_byte == `LMSC_OP_SUPPLY);
  wire [31:0] full_param = {param[23:0], rx_byte};
  wire [7:0]  dev_status = {1'b0, sys_ready, frame_sent, err_code, amp_on};   // R1 R2

  // Parameter bytes carried by each command; zero for pure reads
  always @* begin
    case (cur_op)
      `LMSC_OP_SEND_BIT, `LMSC_OP_CARRIER: param_len = 3'h1;
      `LMSC_OP_SYS_CONF, `LMSC_OP_TX_TEST, `LMSC_OP_RX_TEST,
      `LMSC_OP_TX_FREQ,  `LMSC_OP_RX_FREQ: param_len = 3'h4;
      default:                             param_len = 3'h0;
    endcase
  end

  wire known_op = (cur_op == `LMSC_OP_STATUS)   | (cur_op == `LMSC_OP_SEND_BIT) |
                  (cur_op == `LMSC_OP_SEND_FRM) | (cur_op == `LMSC_OP_SEND_RCV) |
                  (cur_op == `LMSC_OP_REG_CODE) | (cur_op == `LMSC_OP_RX_READ)  |
                  ((cur_op >= `LMSC_OP_SYS_CONF) && (cur_op <= `LMSC_OP_CARRIER)) |
                  (cur_op == `LMSC_OP_TX_FREQ)  | (cur_op == `LMSC_OP_RX_FREQ);

  // Byte to present for position next_idx; positions 0 and 1 are dummies
  always @* begin
    data_idx     = next_idx - `LMSC_FIRST_DATA;
    next_tx_byte = 8'h00;
    if (next_idx >= `LMSC_FIRST_DATA) begin
      case (cur_op)
        `LMSC_OP_STATUS: begin
          case (data_idx)                                      // R4
            5'h00:   next_tx_byte = status_snap[23:16];
            5'h01:   next_tx_byte = status_snap[15:8];
            5'h02:   next_tx_byte = status_snap[7:0];
            default: next_tx_byte = 8'h00;
          endcase
        end
        `LMSC_OP_REG_CODE: begin
          if (data_idx < `LMSC_REG_CODE_USED)                  // R9
            next_tx_byte = registration_code[(7 - data_idx[2:0]) * 8 +: 8];
        end
        `LMSC_OP_RX_READ: begin
          if (data_idx < 5'h08)                                // R10
            next_tx_byte = rx_packet[(7 - data_idx[2:0]) * 8 +: 8];
        end
        `LMSC_OP_GET_ID: begin
          if (data_idx < 5'h04)                                // R13
            next_tx_byte = device_identifier[(3 - data_idx[1:0]) * 8 +: 8];
        end
        `LMSC_OP_SUPPLY: begin
          case (data_idx)                                      // R14
            5'h00:   next_tx_byte = idle_supply_mv[15:8];
            5'h01:   next_tx_byte = idle_supply_mv[7:0];
            5'h02:   next_tx_byte = active_supply_mv[15:8];
            5'h03:   next_tx_byte = active_supply_mv[7:0];
            5'h04:   next_tx_byte = raw_temperature_word[15:8];
            5'h05:   next_tx_byte = raw_temperature_word[7:0];
            default: next_tx_byte = 8'h00;
          endcase
        end
        default: next_tx_byte = 8'h00;
      endcase
    end
  end

  // Pin synchronisers; only stage 1 and later feed logic
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      sclk_sy <= 3'h0;
      cs_sy   <= 3'h7;
      mosi_sy <= 2'h0;
    end else begin
      sclk_sy <= {sclk_sy[1:0], sclk};
      cs_sy   <= {cs_sy[1:0], cs_b};
      mosi_sy <= {mosi_sy[0], mosi};
    end
  end

  // Serial shifting: sample on rising edge, advance output on falling
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      bit_cnt  <= 3'h0;
      rx_sh    <= 8'h00;
      tx_sh    <= 8'h00;
      byte_idx <= 5'h00;
      opcode   <= 8'h00;
      param    <= 32'h0;
      done_cmd <= 1'b0;
      miso     <= 1'b0;
      miso_oe  <= 1'b0;
    end else begin
      miso_oe <= cs_act;
      miso    <= tx_sh[7];
      if (!cs_act) begin
        // Frame ends with chip select; a partial command is dropped
        bit_cnt  <= 3'h0;
        byte_idx <= 5'h00;
        done_cmd <= 1'b0;                                      // R26
        // Cleared so a cut frame's leftover byte never leads the next frame
        tx_sh    <= 8'h00;
      end else if (sclk_rise) begin
        rx_sh   <= rx_byte;                                    // R24
        bit_cnt <= bit_cnt + 3'h1;
        if (bit_cnt == 3'h7) begin
          byte_idx <= next_idx;
          tx_sh    <= next_tx_byte;
          if (byte_idx == 5'h00) begin
            opcode   <= rx_byte;
            param    <= 32'h0;
            done_cmd <= (param_len == 3'h0);
          end else begin
            param <= full_param;
            if (is_last_param)
              done_cmd <= 1'b1;
          end
        end
      end else if (sclk_fall && bit_cnt != 3'h0) begin
        tx_sh <= {tx_sh[6:0], 1'b0};
      end
    end
  end

  // Command execution: start pulses and settings
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      send_bit_start      <= 1'b0;
      send_bit_value      <= 1'b0;
      send_frame_start    <= 1'b0;
      send_recv_start     <= 1'b0;
      meas_start          <= 1'b0;
      nv_write_start      <= 1'b0;
      port_direction_byte <= 8'h00;
      port_level_byte     <= 8'h00;
      system_config_byte  <= 8'h00;
      tx_test_start       <= 1'b0;
      rx_test_start       <= 1'b0;
      frame_count         <= 16'h0000;
      sequence_word       <= 16'h0000;
      channel_word        <= 16'h0000;
      continuous_carrier  <= 1'b0;
      tx_freq_hz          <= `LMSC_TX_FREQ_DEF;                // R20
      rx_freq_hz          <= `LMSC_RX_FREQ_DEF;                // R21
    end else begin
      send_bit_start   <= is_last_param & (opcode == `LMSC_OP_SEND_BIT) & (rx_byte[7:1] == 7'h00); // R5
      send_frame_start <= op_taken & (rx_byte == `LMSC_OP_SEND_FRM);                              // R6 R7
      send_recv_start  <= op_taken & (rx_byte == `LMSC_OP_SEND_RCV);                              // R8
      meas_start       <= op_taken & (rx_byte == `LMSC_OP_MEASURE);                               // R16
      nv_write_start   <= is_last_param & (opcode == `LMSC_OP_SYS_CONF) &
                          (param[7:0] == `LMSC_CONF_MARK);                                         // R11
      tx_test_start    <= is_last_param & (opcode == `LMSC_OP_TX_TEST);
      rx_test_start    <= is_last_param & (opcode == `LMSC_OP_RX_TEST);
      if (is_last_param) begin
        case (opcode)
          `LMSC_OP_SEND_BIT: begin
            if (rx_byte[7:1] == 7'h00)                         // R5
              send_bit_value <= rx_byte[0];
          end
          `LMSC_OP_SYS_CONF: begin
            port_direction_byte <= full_param[31:24];          // R12
            port_level_byte     <= full_param[23:16];          // R12
            system_config_byte  <= full_param[7:0];
          end
          `LMSC_OP_TX_TEST: begin
            frame_count  <= {full_param[23:16], full_param[31:24]};  // R17
            channel_word <= {full_param[7:0], full_param[15:8]};
          end
          `LMSC_OP_RX_TEST: begin
            sequence_word <= {full_param[23:16], full_param[31:24]}; // R18
            channel_word  <= {full_param[7:0], full_param[15:8]};
          end
          `LMSC_OP_CARRIER: begin
            if (rx_byte == `LMSC_CARRIER_ON)                   // R19
              continuous_carrier <= 1'b1;
            else if (rx_byte == `LMSC_CARRIER_OFF)
              continuous_carrier <= 1'b0;
          end
          `LMSC_OP_TX_FREQ:
            tx_freq_hz <= full_param;                          // R20
          `LMSC_OP_RX_FREQ:
            rx_freq_hz <= full_param;                          // R21
          default: ;
        endcase
      end
    end
  end

  // Status bytes and event flags; a completion in the clearing cycle wins
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      sys_ready   <= 1'b1;
      ev_ready    <= 1'b1;                                     // R23
      frame_sent  <= 1'b0;
      err_code    <= `LMSC_ERR_NONE;
      lib_status  <= `LMSC_LIB_NONE;
      ev_radio    <= 1'b0;
      ev_meas     <= 1'b0;
      ev_nv       <= 1'b0;
      status_snap <= 24'h0;
      completion_event_pin_b <= 1'b1;
    end else begin
      if (status_rd) begin
        status_snap <= {hardware_state_status, dev_status, lib_status};  // R4
        sys_ready   <= 1'b0;                                   // R22
        ev_ready    <= 1'b0;
        frame_sent  <= 1'b0;
        err_code    <= `LMSC_ERR_NONE;
        lib_status  <= `LMSC_LIB_NONE;
        ev_radio    <= 1'b0;
        ev_meas     <= 1'b0;
        ev_nv       <= 1'b0;
      end
      if (supply_rd)
        ev_meas <= 1'b0;                                       // R16
      if (op_taken && !known_op)
        err_code <= `LMSC_ERR_CMD;                             // R2
      if (is_last_param && opcode == `LMSC_OP_SYS_CONF && param[7:0] != `LMSC_CONF_MARK)
        err_code <= `LMSC_ERR_USAGE;
      if (radio_done) begin
        ev_radio   <= 1'b1;                                    // R23 R8
        frame_sent <= radio_frame_sent | (frame_sent & ~status_rd);
        lib_status <= radio_lib_status;                        // R3
        if (radio_error_code != `LMSC_ERR_NONE)
          err_code <= radio_error_code;
      end
      if (meas_done)
        ev_meas <= 1'b1;                                       // R16
      if (nv_done)
        ev_nv <= 1'b1;                                         // R11
      completion_event_pin_b <= ~(ev_ready | ev_radio | ev_meas | ev_nv);  // R23
    end
  end

  // Front-end control follows the engine's radio direction
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      front_end_enable_pin    <= 1'b0;
      front_end_direction_pin <= 1'b0;
    end else begin
      front_end_enable_pin    <= uplink_active | downlink_active;  // R25
      front_end_direction_pin <= uplink_active;                    // R25
    end
  end

endmodule // lmsc_cmd

// >>> tb/lmsc_host.sv
/*
  SPI host model: mode 0, MSB first, one command per chip-select frame.
  Assumes ref_clk at 25 ns; the 200 ns serial clock is built from it.
*/
module lmsc_host (
  // Clock
  input  wire logic ref_clk,
  // SPI pins
  output logic      sclk,
  output logic      cs_b,
  output logic      mosi,
  input  wire logic miso
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] tx [0:19];
  logic [7:0] rx [0:19];
  initial begin
    {sclk, cs_b, mosi} = 3'b010;
  end
  task automatic half();
    repeat (4) @(negedge ref_clk);
  endtask
  task automatic xfer(input int n);
    @(negedge ref_clk);
    cs_b = 1'b0;
    repeat (10) half();
    for (int i = 0; i < n; i++) begin
      for (int b = 7; b >= 0; b--) begin
        mosi = tx[i][b];
        half();
        sclk = 1'b1;
        rx[i][b] = miso;
        half();
        sclk = 1'b0;
      end
    end
    repeat (10) half();
    cs_b = 1'b1;
    // Idle data line flips so a stale level is never mistaken for data
    mosi = ~mosi;
    repeat (25) half();
  endtask
endmodule // lmsc_host

// >>> tb/lmsc_cmd_props.sv
/*
  Checker on the interpreter's ports: event timing, front-end pins,
  output enable framing and frequency hold. Bound to lmsc_cmd below.
*/
module lmsc_cmd_props (
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        rst_b,
  // Watched ports
  input wire logic        cs_b,
  input wire logic        miso_oe,
  input wire logic        completion_event_pin_b,
  input wire logic        front_end_enable_pin,
  input wire logic        front_end_direction_pin,
  input wire logic        uplink_active,
  input wire logic        downlink_active,
  input wire logic        radio_done,
  input wire logic        meas_done,
  input wire logic        nv_done,
  input wire logic [31:0] tx_freq_hz,
  input wire logic [31:0] rx_freq_hz
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  // Flag sets on the next edge, pin follows one edge later
  sequence s_evt_low;
    ##[1:2] !completion_event_pin_b;
  endsequence
  property p_ready_evt; !$past(rst_b) |-> ##[0:1] !completion_event_pin_b; endproperty
  a_ready_evt: assert property (p_ready_evt) else $error("no ready event after reset");
  property p_radio_evt; radio_done |-> s_evt_low; endproperty
  a_radio_evt: assert property (p_radio_evt) else $error("no event after radio done");
  property p_meas_evt; meas_done |-> s_evt_low; endproperty
  a_meas_evt: assert property (p_meas_evt) else $error("no event after measurement");
  property p_nv_evt; nv_done |-> s_evt_low; endproperty
  a_nv_evt: assert property (p_nv_evt) else $error("no event after config write");
  property p_fe_up; uplink_active |=> front_end_enable_pin && front_end_direction_pin; endproperty
  a_fe_up: assert property (p_fe_up) else $error("front end not in uplink");
  property p_fe_down; downlink_active && !uplink_active |=> front_end_enable_pin && !front_end_direction_pin; endproperty
  a_fe_down: assert property (p_fe_down) else $error("front end not in downlink");
  property p_oe_frame; !cs_b [*5] |-> miso_oe; endproperty
  a_oe_frame: assert property (p_oe_frame) else $error("data out not enabled in frame");
  property p_freq_hold; $changed(tx_freq_hz) || $changed(rx_freq_hz) |-> !cs_b; endproperty
  a_freq_hold: assert property (p_freq_hold) else $error("frequency changed outside a frame");
endmodule // lmsc_cmd_props
bind lmsc_cmd lmsc_cmd_props lmsc_cmd_props_inst (.ref_clk, .rst_b, .cs_b, .miso_oe, .completion_event_pin_b,
  .front_end_enable_pin, .front_end_direction_pin, .uplink_active, .downlink_active, .radio_done, .meas_done,
  .nv_done, .tx_freq_hz, .rx_freq_hz);

// >>> tb/tb.sv
/*
  Bench top: interpreter, SPI host model and a hand-driven engine stub.
  Assumes the host model makes one whole frame per call.
*/
`include "lmsc_consts.vh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk, rst_b, sclk, cs_b, mosi, miso, miso_oe, amp_on, uplink_active, downlink_active;
  logic        radio_done, radio_frame_sent, meas_done, nv_done, completion_event_pin_b, front_end_enable_pin;
  logic        front_end_direction_pin, send_bit_start, send_bit_value, send_frame_start, send_recv_start;
  logic        meas_start, nv_write_start, tx_test_start, rx_test_start, continuous_carrier;
  logic [3:0]  radio_error_code;
  logic [7:0]  hardware_state_status, radio_lib_status, port_direction_byte, port_level_byte, system_config_byte;
  logic [15:0] idle_supply_mv, active_supply_mv, raw_temperature_word, frame_count, sequence_word, channel_word;
  logic [31:0] device_identifier, tx_freq_hz, rx_freq_hz;
  logic [63:0] rx_packet, registration_code;
  logic [6:0]  seen;
  logic        seen_clr;
  int          n_mismatch = 0;
  int          cmp_count = 0;
  lmsc_cmd lmsc_cmd_inst (
    .ref_clk(ref_clk), .rst_b(rst_b), .sclk(sclk), .cs_b(cs_b), .mosi(mosi), .miso(miso), .miso_oe(miso_oe),
    .completion_event_pin_b(completion_event_pin_b), .front_end_enable_pin(front_end_enable_pin),
    .front_end_direction_pin(front_end_direction_pin), .hardware_state_status(hardware_state_status),
    .amp_on(amp_on), .uplink_active(uplink_active), .downlink_active(downlink_active), .radio_done(radio_done),
    .radio_frame_sent(radio_frame_sent), .radio_error_code(radio_error_code), .radio_lib_status(radio_lib_status),
    .meas_done(meas_done), .nv_done(nv_done), .rx_packet(rx_packet), .registration_code(registration_code),
    .device_identifier(device_identifier), .idle_supply_mv(idle_supply_mv), .active_supply_mv(active_supply_mv),
    .raw_temperature_word(raw_temperature_word), .send_bit_start(send_bit_start), .send_bit_value(send_bit_value),
    .send_frame_start(send_frame_start), .send_recv_start(send_recv_start), .meas_start(meas_start),
    .nv_write_start(nv_write_start), .port_direction_byte(port_direction_byte), .port_level_byte(port_level_byte),
    .system_config_byte(system_config_byte), .tx_test_start(tx_test_start), .frame_count(frame_count),
    .rx_test_start(rx_test_start), .sequence_word(sequence_word), .channel_word(channel_word),
    .continuous_carrier(continuous_carrier), .tx_freq_hz(tx_freq_hz), .rx_freq_hz(rx_freq_hz));
  lmsc_host lmsc_host_inst (.ref_clk(ref_clk), .sclk(sclk), .cs_b(cs_b), .mosi(mosi), .miso(miso));
  // Start pulses last one cycle, so they are caught in sticky bits
  always @(posedge ref_clk)
    seen <= (seen_clr ? 7'h00 : seen) | {send_bit_start, send_frame_start, send_recv_start, meas_start, nv_write_start,
                    tx_test_start, rx_test_start};
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  task automatic chk(input logic [63:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic cmd(input int n, input logic [39:0] hd);
    for (int i = 0; i < 20; i++)
      lmsc_host_inst.tx[i] = (i < 5) ? hd[39 - 8 * i -: 8] : 8'h00;
    @(negedge ref_clk);
    seen_clr = 1'b1;
    @(negedge ref_clk);
    seen_clr = 1'b0;
    lmsc_host_inst.xfer(n);
  endtask
  function automatic logic [7:0] rd(input int i);
    return lmsc_host_inst.rx[i];
  endfunction
  task automatic done(input int k);
    @(negedge ref_clk);
    {radio_done, meas_done, nv_done} = {k == 0, k == 1, k == 2};
    @(negedge ref_clk);
    {radio_done, meas_done, nv_done} = 3'b000;
    repeat (3) @(negedge ref_clk);
    chk(completion_event_pin_b, 1'b0);
  endtask
  task automatic status(input logic [7:0] dev, lib);
    cmd(5, {`LMSC_OP_STATUS, 32'h0});
    chk({rd(2), rd(3), rd(4)}, {hardware_state_status, dev, lib});
    chk(completion_event_pin_b, 1'b1);
  endtask
  task automatic t_reset();
    @(negedge ref_clk);
    rst_b = 1'b0;
    repeat (20) @(negedge ref_clk);
    rst_b = 1'b1;
    repeat (3) @(negedge ref_clk);
    chk(completion_event_pin_b, 1'b0);
    chk({tx_freq_hz, rx_freq_hz}, {`LMSC_TX_FREQ_DEF, `LMSC_RX_FREQ_DEF});
    status(8'h41, 8'h00);
  endtask
  task automatic t_radio();
    cmd(1, {`LMSC_OP_SEND_FRM, 32'h0});
    chk(seen, 7'h20);
    {uplink_active, radio_frame_sent, radio_error_code, radio_lib_status} = {2'b11, 4'h7, 8'h10};
    done(0);
    chk({front_end_enable_pin, front_end_direction_pin}, 2'b11);
    uplink_active = 1'b0;
    status(8'h2f, 8'h10);
    cmd(1, {`LMSC_OP_SEND_RCV, 32'h0});
    chk(seen, 7'h10);
    {downlink_active, radio_frame_sent, radio_error_code, radio_lib_status} = 14'h2000;
    done(0);
    chk({front_end_enable_pin, front_end_direction_pin}, 2'b10);
    downlink_active = 1'b0;
    status(8'h01, 8'h00);
    cmd(10, {`LMSC_OP_RX_READ, 32'h0});
    for (int i = 0; i < 8; i++)
      chk(rd(2 + i), rx_packet[63 - 8 * i -: 8]);
  endtask
  task automatic t_bit();
    cmd(1, {8'h08, 32'h0});
    status(8'h03, 8'h00);
    cmd(2, {`LMSC_OP_SEND_BIT, 8'h01, 24'h0});
    chk({seen, send_bit_value}, 8'h81);
    cmd(2, {`LMSC_OP_SEND_BIT, 8'h00, 24'h0});
    chk({seen, send_bit_value}, 8'h80);
    cmd(2, {`LMSC_OP_SEND_BIT, 8'h03, 24'h0});
    chk({seen, send_bit_value}, 8'h00);
  endtask
  task automatic t_reads();
    cmd(18, {`LMSC_OP_REG_CODE, 32'h0});
    for (int i = 0; i < 16; i++)
      chk(rd(2 + i), (i < 8) ? registration_code[63 - 8 * i -: 8] : 8'h00);
    cmd(3, {`LMSC_OP_GET_ID, 32'h0});
    chk(rd(2), device_identifier[31:24]);
    cmd(6, {`LMSC_OP_GET_ID, 32'h0});
    chk({rd(0), rd(2), rd(3), rd(4), rd(5)}, {8'h00, device_identifier});
    cmd(1, {`LMSC_OP_MEASURE, 32'h0});
    chk(seen, 7'h08);
    done(1);
    cmd(8, {`LMSC_OP_SUPPLY, 32'h0});
    chk({rd(2), rd(3), rd(4), rd(5), rd(6), rd(7)}, {idle_supply_mv, active_supply_mv, raw_temperature_word});
    chk(({rd(6), rd(7)} - 16'h01f4) / 16'h000a, 16'h000a);
    chk(completion_event_pin_b, 1'b1);
  endtask
  task automatic t_conf();
    cmd(5, {`LMSC_OP_SYS_CONF, 16'ha53c, `LMSC_CONF_MARK, 8'hf7});
    chk({seen, port_direction_byte, port_level_byte, system_config_byte}, {7'h04, 24'ha53cf7});
    done(2);
    status(8'h01, 8'h00);
    cmd(5, {`LMSC_OP_SYS_CONF, 32'h11220344});
    chk({seen, port_direction_byte}, {7'h00, 8'h11});
    status(8'h09, 8'h00);
  endtask
  task automatic t_tests();
    cmd(5, {`LMSC_OP_TX_TEST, 32'h0080e001});
    chk({seen, frame_count, channel_word}, {7'h02, 32'h800001e0});
    cmd(5, {`LMSC_OP_RX_TEST, 32'h3412df01});
    chk({seen, sequence_word, channel_word}, {7'h01, 32'h123401df});
    cmd(2, {`LMSC_OP_CARRIER, `LMSC_CARRIER_ON, 24'h0});
    chk(continuous_carrier, 1'b1);
    cmd(2, {`LMSC_OP_CARRIER, `LMSC_CARRIER_OFF, 24'h0});
    chk(continuous_carrier, 1'b0);
    cmd(5, {`LMSC_OP_TX_FREQ, 32'h33c5c8c0});
    cmd(5, {`LMSC_OP_RX_FREQ, 32'h33d1fdc0});
    chk({tx_freq_hz, rx_freq_hz}, 64'h33c5c8c0_33d1fdc0);
    t_reset();
  endtask
  initial begin
    rst_b = 1'b0;
    {amp_on, uplink_active, downlink_active, radio_done, radio_frame_sent, meas_done, nv_done} = 7'h40;
    {radio_error_code, radio_lib_status, hardware_state_status, seen_clr} = 21'h000169;
    {rx_packet, registration_code} = 128'h0123456789abcdef_fedcba9876543210;
    device_identifier = 32'h1a2b3c4d;
    {idle_supply_mv, active_supply_mv, raw_temperature_word} = 48'h0ce40c1c0258;
    t_reset();
    t_radio();
    t_bit();
    t_reads();
    t_conf();
    t_tests();
    end_sim();
  end
  initial begin
    #1500us;
    n_mismatch++;
    end_sim();
  end
endmodule // tb
